// file: src/adc_frame_defs.svh
// constants for the serial command frame block
`ifndef ADC_FRAME_DEFS_SVH
`define ADC_FRAME_DEFS_SVH
// ==========================================================
// command word fields and opcodes
`define WORD_BITS 5'd22
`define CMD_OP 21:17
`define CMD_ADDR 16:8
`define CMD_DATA 7:0
`define OP_CLEAR 5'h10
`define OP_READ 5'h11
`define OP_WRITE 5'h12
`define OP_SET 5'h13
`define IN_SHIFT_CLEAR 22'h000000
// ==========================================================
// output word fields
`define OUT_VALUE 21:4
`define OUT_READBACK 21:14
`define OUT_FULL_PAR 3
`define OUT_PART_PAR 2
`define OUT_LOW 1:0
`define SPAN_MASK_0 18'h3FC00
`define SPAN_MASK_1 18'h3FFC0
`define SPAN_MASK_2 18'h3FFFC
`define SPAN_MASK_3 18'h3FFFF
// ==========================================================
// configuration registers
`define REG_BASE 9'h010
`define REG_COUNT 4
`define REG_IDX 1:0
`define REG_RESET 8'h00
`define CTRL_IDX 0
`define PATN_LO_IDX 1
`define PATN_MID_IDX 2
`define PATN_HI_IDX 3
`define PATN_HI_BITS 1:0
`define CTRL_PAT_SEL 0
`define CTRL_PARITY_ENABLE_BIT 1
`define CTRL_SPAN 3:2
// ==========================================================
// pin sampler layout and timing
`define P_RSTN 3
`define P_CSN 2
`define P_SCLK 1
`define P_SDI 0
`define PIN_IDLE 4'h4
`define CLK_PERIOD_NS 50
`define READY_DELAY_NS 100
`define READY_CYCLES ((`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_BITS 18
`define FIFO_DEPTH 16
`endif

// file: src/adc_frame_pkg.sv
// types shared by the serial command frame block
package adc_frame_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_DECODE, ST_SETTLE} frame_state_type;
  typedef logic [21:0] word_type;
  typedef logic [7:0] byte_type;
  typedef logic [17:0] result_type;
endpackage

// file: src/adc_serial_command_frame.sv
// serial command and readout frame logic of the sampling converter
// ==========================================================
// Summary of operation
// - command is opcode, 9-bit address, 8-bit data
// - write stores data; read selects readback
// - masked set and clear touch masked bits
// - all other opcodes do nothing
// - command bits captured on serial clock edges
// - readback frame with pattern select off: register byte, then zeros
// - pattern select replaces value with fixed pattern
// - otherwise value is latest conversion result
// - parity disabled drives both parity bits zero
// - parity bits: full value, selected span
// - two lowest output bits always zero
// - frame from select low to high, started only from idle
// - frame start: strobe low, clear, load, reset
// - capture edge shifts in, launch shifts out
// - frame end: hi-z, decode, delayed strobe
// - fewer than 22 edges: frame ignored
// - exactly 22 edges: word decoded
// - more than 22: last 22 kept
// - between frames strobe follows conversion busy
// - reset restores defaults, strobe low, hi-z
`timescale 1ns/1ps
`default_nettype none
`include "adc_frame_defs.svh"
module adc_serial_command_frame (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RST_N_I,
  input wire logic CS_N_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  input wire logic CONVERSION_BUSY_N_I,
  input wire logic RESULT_VALID_I,
  input wire adc_frame_pkg::result_type RESULT_DATA_I,
  output logic RESULT_READY_O,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  output logic READY_STROBE_O
);
  import adc_frame_pkg::*;

  // ==========================================================
  // pin sampling
  logic [3:0] s1, s2, s3;
  logic [3:0] next_s1, next_s2, next_s3;
  logic rst, cs_low, cs_high, cap, launch, serial_in_line;

  always_comb begin
    next_s1 = {RST_N_I, CS_N_I, SCLK_I, SDI_I};
    next_s2 = s1;
    next_s3 = s2;
  end

  // reset pin starts low so the block waits for its release
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s1 <= `PIN_IDLE;
      s2 <= `PIN_IDLE;
      s3 <= `PIN_IDLE;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign rst = SYS_RST_I || !s2[`P_RSTN];
  assign cs_low = !s2[`P_CSN];
  assign cs_high = s2[`P_CSN];
  // sdi passes the same two stages, so it lines up with the edge
  assign cap = s2[`P_SCLK] && !s3[`P_SCLK];
  assign launch = !s2[`P_SCLK] && s3[`P_SCLK];
  assign serial_in_line = s2[`P_SDI];

  // ==========================================================
  // result fifo
  stream_if #(.WIDTH(`RESULT_BITS)) in_s ();
  stream_if #(.WIDTH(`RESULT_BITS)) out_s ();

  assign in_s.valid = RESULT_VALID_I;
  assign in_s.data = RESULT_DATA_I;
  assign RESULT_READY_O = in_s.ready;

  result_fifo #(
    .WIDTH(`RESULT_BITS),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(rst),
    .in_s(in_s),
    .out_s(out_s)
  );

  // ==========================================================
  // frame state
  frame_state_type state, next_state;
  logic [4:0] bit_cnt, next_cnt;
  word_type ins, next_ins;
  word_type shift_out, next_shift_out;
  logic oe_n, next_oe_n;
  logic strobe, next_strobe;
  logic [2:0] dly, next_dly;
  word_type out_word;
  logic cmd_valid;

  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_ins = ins;
    next_shift_out = shift_out;
    next_oe_n = oe_n;
    next_strobe = strobe;
    next_dly = dly;
    case (state)
      ST_IDLE: begin
        next_strobe = CONVERSION_BUSY_N_I;
        if (cs_low) begin
          next_state = ST_ACTIVE;
          next_strobe = 1'b0;
          next_cnt = '0;
          next_shift_out = out_word;
          next_ins = `IN_SHIFT_CLEAR;
          next_oe_n = 1'b0;
        end
      end
      ST_ACTIVE: begin
        if (cs_high) begin
          next_state = ST_DECODE;
          next_oe_n = 1'b1;
        end else begin
          if (cap) begin
            // oldest bits fall off the top, keeping the last 22
            next_ins = {ins[20:0], serial_in_line};
            if (bit_cnt != `WORD_BITS) begin
              next_cnt = bit_cnt + 5'd1;
            end
          end
          if (launch) begin
            next_shift_out = {shift_out[20:0], 1'b0};
          end
        end
      end
      ST_DECODE: begin
        next_state = ST_SETTLE;
        next_dly = 3'(`READY_CYCLES);
      end
      ST_SETTLE: begin
        if (dly <= 3'd1) begin
          next_state = ST_IDLE;
        end else begin
          next_dly = dly - 3'd1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      ins <= `IN_SHIFT_CLEAR;
      shift_out <= '0;
      oe_n <= 1'b1;
      strobe <= 1'b0;
      dly <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      ins <= next_ins;
      shift_out <= next_shift_out;
      oe_n <= next_oe_n;
      strobe <= next_strobe;
      dly <= next_dly;
    end
  end

  assign SDO_O = shift_out[21];
  assign SDO_OE_N_O = oe_n;
  assign READY_STROBE_O = strobe;

  // short frames never reach the decoder
  assign cmd_valid = (state == ST_DECODE) && (bit_cnt == `WORD_BITS);

  // ==========================================================
  // configuration registers
  byte_type reg_rd;
  logic pat_sel, parity_enable_bit;
  logic [1:0] span;
  result_type pattern;

  // decode lands two cycles before the settle wait ends
  config_regs u_regs (
    .clk_i(CLK_I),
    .rst_i(rst),
    .cmd_valid_i(cmd_valid),
    .cmd_i(ins),
    .rd_data_o(reg_rd),
    .pattern_select_bit_o(pat_sel),
    .parity_enable_bit_o(parity_enable_bit),
    .parity_span_select_o(span),
    .fixed_pattern_field_o(pattern)
  );

  // ==========================================================
  // result, readback and output word
  result_type result, next_result;
  logic rd_pending, next_rd_pending;
  byte_type rd_byte, next_rd_byte;
  result_type value, mask;

  // fifo drains only between frames so results pile up meanwhile
  assign out_s.ready = (state == ST_IDLE);

  always_comb begin
    next_result = result;
    next_rd_pending = rd_pending;
    next_rd_byte = rd_byte;
    if (out_s.valid && out_s.ready) begin
      next_result = out_s.data;
    end
    if (state == ST_IDLE && cs_low) begin
      next_rd_pending = 1'b0;
    end
    if (cmd_valid && ins[`CMD_OP] == `OP_READ) begin
      next_rd_pending = 1'b1;
      next_rd_byte = reg_rd;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      result <= '0;
      rd_pending <= 1'b0;
      rd_byte <= '0;
    end else begin
      result <= next_result;
      rd_pending <= next_rd_pending;
      rd_byte <= next_rd_byte;
    end
  end

  always_comb begin
    value = pat_sel ? pattern : result;
    case (span)
      2'd0: mask = `SPAN_MASK_0;
      2'd1: mask = `SPAN_MASK_1;
      2'd2: mask = `SPAN_MASK_2;
      default: mask = `SPAN_MASK_3;
    endcase
    out_word = '0;
    if (!pat_sel && rd_pending) begin
      out_word[`OUT_READBACK] = rd_byte;
    end else begin
      out_word[`OUT_VALUE] = value;
      if (parity_enable_bit) begin
        out_word[`OUT_FULL_PAR] = ^value;
        out_word[`OUT_PART_PAR] = ^(value & mask);
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (rst);

  a_frame_start: assert property (
    state == ST_IDLE && cs_low |=> state == ST_ACTIVE && !strobe && !oe_n
      && bit_cnt == 5'd0 && ins == `IN_SHIFT_CLEAR && shift_out == $past(out_word))
    else $error("frame start did not load and clear");
  a_capture_shift: assert property (
    state == ST_ACTIVE && !cs_high && cap
    |=> ins == {$past(ins[20:0]), $past(serial_in_line)})
    else $error("capture edge did not shift input");
  a_launch_shift: assert property (
    state == ST_ACTIVE && !cs_high && launch |=> shift_out == {$past(shift_out[20:0]), 1'b0})
    else $error("launch edge did not shift output");
  a_frame_end: assert property (
    state == ST_ACTIVE && cs_high |=> oe_n && state == ST_DECODE ##1 !strobe ##1 !strobe
      ##1 !strobe)
    else $error("frame end sequence wrong");
  a_short_ignored: assert property (
    state == ST_DECODE && bit_cnt < `WORD_BITS |-> !cmd_valid)
    else $error("short frame decoded");
  a_full_decoded: assert property (
    state == ST_DECODE && bit_cnt == `WORD_BITS |-> cmd_valid)
    else $error("full frame not decoded");
  a_idle_follows: assert property (
    state == ST_IDLE && !cs_low |=> strobe == $past(CONVERSION_BUSY_N_I))
    else $error("strobe does not follow busy");
  a_readback_word: assert property (
    rd_pending && !pat_sel |-> out_word == {rd_byte, 14'h0000})
    else $error("readback word wrong");
  a_pattern_word: assert property (
    pat_sel |-> out_word[`OUT_VALUE] == pattern)
    else $error("pattern not in output");
  a_result_word: assert property (
    !pat_sel && !rd_pending |-> out_word[`OUT_VALUE] == result)
    else $error("result not in output");
  a_parity_off: assert property (
    !parity_enable_bit |-> out_word[3:2] == 2'b00 && out_word[`OUT_LOW] == 2'b00)
    else $error("parity bits not zero");
  a_parity_full: assert property (
    parity_enable_bit && !(rd_pending && !pat_sel) |-> out_word[`OUT_FULL_PAR] == ^out_word[`OUT_VALUE])
    else $error("full parity wrong");
  a_low_zero: assert property (
    out_word[`OUT_LOW] == 2'b00)
    else $error("low bits not zero");
  a_reset_quiet: assert property (
    @(posedge CLK_I) disable iff (1'b0) SYS_RST_I |=> !strobe && oe_n)
    else $error("reset left strobe high or output driven");
endmodule
`default_nettype wire

// file: src/config_regs.sv
// configuration registers written by decoded commands
`timescale 1ns/1ps
`default_nettype none
`include "adc_frame_defs.svh"
module config_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire adc_frame_pkg::word_type cmd_i,
  output adc_frame_pkg::byte_type rd_data_o,
  output logic pattern_select_bit_o,
  output logic parity_enable_bit_o,
  output logic [1:0] parity_span_select_o,
  output adc_frame_pkg::result_type fixed_pattern_field_o
);
  import adc_frame_pkg::*;
  byte_type regs [`REG_COUNT];
  byte_type next_regs [`REG_COUNT];
  logic [8:0] idx;
  logic hit;
  logic [4:0] op;
  byte_type data;
  assign op = cmd_i[`CMD_OP];
  assign data = cmd_i[`CMD_DATA];
  assign idx = cmd_i[`CMD_ADDR] - `REG_BASE;
  assign hit = (idx < 9'(`REG_COUNT));
  // unmapped addresses read as zero
  assign rd_data_o = hit ? regs[idx[`REG_IDX]] : '0;
  assign pattern_select_bit_o = regs[`CTRL_IDX][`CTRL_PAT_SEL];
  assign parity_enable_bit_o = regs[`CTRL_IDX][`CTRL_PARITY_ENABLE_BIT];
  assign parity_span_select_o = regs[`CTRL_IDX][`CTRL_SPAN];
  assign fixed_pattern_field_o = {regs[`PATN_HI_IDX][`PATN_HI_BITS], regs[`PATN_MID_IDX],
                                  regs[`PATN_LO_IDX]};
  // ==========================================================
  // per-register update
  for (genvar e = 0; e < `REG_COUNT; e++) begin : g_reg
    always_comb begin
      next_regs[e] = regs[e];
      if (cmd_valid_i && hit && idx == 9'(e)) begin
        case (op)
          `OP_WRITE: next_regs[e] = data;
          `OP_SET: next_regs[e] = regs[e] | data;
          `OP_CLEAR: next_regs[e] = regs[e] & ~data;
          default: next_regs[e] = regs[e];
        endcase
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs[e] <= `REG_RESET;
      end else begin
        regs[e] <= next_regs[e];
      end
    end
  end
  // ==========================================================
  // checks on the control register
  a_write_stores: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i[`CMD_ADDR] == `REG_BASE && op == `OP_WRITE
    |=> regs[`CTRL_IDX] == $past(data))
    else $error("write did not store data");
  a_mask_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i[`CMD_ADDR] == `REG_BASE && op == `OP_SET
    |=> regs[`CTRL_IDX] == ($past(regs[`CTRL_IDX]) | $past(data)))
    else $error("masked set wrong");
  a_mask_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_i[`CMD_ADDR] == `REG_BASE && op == `OP_CLEAR
    |=> regs[`CTRL_IDX] == ($past(regs[`CTRL_IDX]) & ~$past(data)))
    else $error("masked clear wrong");
  a_noop_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(cmd_valid_i && (op == `OP_WRITE || op == `OP_SET || op == `OP_CLEAR))
    |=> regs[`CTRL_IDX] == $past(regs[`CTRL_IDX]))
    else $error("no-operation changed a register");
endmodule
`default_nettype wire

// file: src/result_fifo.sv
// conversion result fifo with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic full, empty, next_full, next_empty, push, pop;
  logic room, next_room;
  // ==========================================================
  // pointers and flags
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;
  // registered not-full copy so the ready pin leaves a flop
  assign in_s.ready = room;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_ptr];
  always_comb begin
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + CW'(push) - CW'(pop);
    next_full = (next_count == CW'(DEPTH));
    next_empty = (next_count == '0);
    next_room = (next_count != CW'(DEPTH));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
      room <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      full <= next_full;
      empty <= next_empty;
      room <= next_room;
    end
  end
  // storage needs no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// file: src/stream_if.sv
// valid/ready stream carrier between the frame logic and its fifo
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 18);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: test/adc_serial_command_frame_tb.sv
// self-checking bench for the serial command frame block
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_frame_tb;
  import adc_frame_pkg::*;
  localparam word_type FULL = 22'h3FFFFF;
  localparam word_type IDLE_CMD = 22'h000000;
  localparam word_type RD_CTRL = {5'h11, 9'h010, 8'h00};
  logic clk, sys_rst, rst_n, busy_n, res_valid;
  result_type res_data, latest, p;
  wire logic cs_n, sclk, serial_in_line, res_ready, sdo, sdo_oe_n, strobe;
  int fails = 0;
  int check_count = 0;
  int got;
  logic [31:0] seed = 32'h8901D807;
  word_type rd;
  logic ok;
  logic [4:0] ops [5] = '{5'h12, 5'h00, 5'h01, 5'h14, 5'h1F};
  int lens [5] = '{10, 22, 22, 22, 22};
  adc_serial_command_frame dut (.CLK_I(clk), .SYS_RST_I(sys_rst), .RST_N_I(rst_n),
    .CS_N_I(cs_n), .SCLK_I(sclk), .SDI_I(serial_in_line), .CONVERSION_BUSY_N_I(busy_n),
    .RESULT_VALID_I(res_valid), .RESULT_DATA_I(res_data), .RESULT_READY_O(res_ready),
    .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .READY_STROBE_O(strobe));
  host_model host (.clk_i(clk), .sdo_i(sdo), .ready_strobe_i(strobe), .cs_n_o(cs_n),
    .sclk_o(sclk), .sdi_o(serial_in_line));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic word_type value_word(result_type v, logic par, logic [1:0] span);
    result_type m;
    m = (span == 2'd0) ? 18'h3FC00 : (span == 2'd1) ? 18'h3FFC0 :
        (span == 2'd2) ? 18'h3FFFC : 18'h3FFFF;
    return {v, par & (^v), par & (^(v & m)), 2'b00};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input word_type got_w, input word_type exp, input word_type msk);
    check_count++;
    if ((got_w & msk) !== (exp & msk)) begin
      fails++;
      $display("BAD %0t word %h expected %h", $time, got_w, exp);
    end
  endtask
  task automatic check_bit(input logic got_b, input logic exp);
    check_count++;
    if (got_b !== exp) begin
      fails++;
      $display("BAD %0t flag %b expected %b", $time, got_b, exp);
    end
  endtask
  // frame then bounded wait on the strobe; a hang ends the run
  task automatic xfer(input int n, input word_type c);
    host.frame(n, c, rd, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t strobe never rose", $time);
      end_of_test();
    end
    check_bit(sdo_oe_n, 1'b1);
  endtask
  // offers random results, keeps the last one taken
  task automatic feed(input int tries, output int taken);
    logic [31:0] r;
    taken = 0;
    @(posedge clk);
    for (int i = 0; i < tries; i++) begin
      r = next_rand();
      res_valid <= 1'b1;
      res_data <= r[17:0];
      @(negedge clk);
      if (res_ready === 1'b1) begin
        taken++;
        latest = r[17:0];
      end
      @(posedge clk);
    end
    res_valid <= 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    rst_n = 1'b1;
    busy_n = 1'b1;
    res_valid = 1'b0;
    res_data = '0;
    latest = '0;
    repeat (15) @(posedge clk);
    @(negedge clk);
    check_bit(strobe, 1'b0);
    check_bit(sdo_oe_n, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(negedge clk);
    check_bit(strobe, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      feed(1, got);
      repeat (6) @(negedge clk);
      xfer(22, i[0] ? FULL : IDLE_CMD);
      check(rd, value_word(latest, 1'b0, 2'd0), FULL);
    end
    $display("test result readout done");
    p = result_type'(next_rand());
    xfer(22, {5'h12, 9'h011, p[7:0]});
    xfer(30, {5'h12, 9'h012, p[15:8]});
    xfer(22, {5'h12, 9'h013, 6'h00, p[17:16]});
    xfer(22, {5'h12, 9'h010, 8'h01});
    xfer(22, IDLE_CMD);
    check(rd, value_word(p, 1'b0, 2'd0), FULL);
    for (int s = 0; s < 4; s++) begin
      xfer(22, {5'h12, 9'h010, 4'h0, s[1:0], 2'b11});
      xfer(22, IDLE_CMD);
      check(rd, value_word(p, 1'b1, s[1:0]), FULL);
    end
    $display("test pattern and parity done");
    xfer(22, {5'h10, 9'h010, 8'h05});
    xfer(22, RD_CTRL);
    check(rd, value_word(latest, 1'b1, 2'd2), FULL);
    xfer(22, {5'h13, 9'h010, 8'hF0});
    check(rd, {8'h0A, 14'h0000}, FULL);
    xfer(22, RD_CTRL);
    xfer(22, IDLE_CMD);
    check(rd, {8'hFA, 14'h0000}, FULL);
    $display("test masked set clear done");
    for (int i = 0; i < 5; i++) begin
      xfer(lens[i], {ops[i], 9'h010, 8'h00});
      check(rd, value_word(latest, 1'b1, 2'd2), word_type'(FULL << (22 - lens[i])));
      xfer(22, RD_CTRL);
      xfer(22, IDLE_CMD);
      check(rd, {8'hFA, 14'h0000}, FULL);
    end
    $display("test ignored commands done");
    @(posedge clk);
    busy_n <= 1'b0;
    repeat (4) @(negedge clk);
    check_bit(strobe, 1'b0);
    @(posedge clk);
    busy_n <= 1'b1;
    repeat (4) @(negedge clk);
    check_bit(strobe, 1'b1);
    $display("test busy follow done");
    // drain pauses inside a frame, so a long frame lets the buffer fill
    fork
      xfer(120, IDLE_CMD);
      begin
        repeat (40) @(posedge clk);
        feed(20, got);
      end
    join
    check_bit(got == 16, 1'b1);
    repeat (40) @(negedge clk);
    xfer(22, IDLE_CMD);
    check(rd, value_word(latest, 1'b1, 2'd2), FULL);
    $display("test buffer fill done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(negedge clk);
    check_bit(strobe, 1'b0);
    check_bit(sdo_oe_n, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(negedge clk);
    xfer(22, RD_CTRL);
    xfer(22, IDLE_CMD);
    check(rd, {8'h00, 14'h0000}, FULL);
    $display("test pin reset done");
    end_of_test();
  end
endmodule
`default_nettype wire

// file: test/host_model.sv
// host controller model driving chip select, serial clock and command input
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic ready_strobe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  import adc_frame_pkg::*;
  // ==========================================================
  // frame driver
  localparam int HALF_NS = 200;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // serial clock stands low outside frames; offset keeps it off the system clock edges
  task automatic frame(input int n, input word_type cmd, output word_type rd, output logic ok);
    int k;
    rd = '0;
    ok = 1'b0;
    @(posedge clk_i);
    #13 cs_n_o = 1'b0;
    #HALF_NS;
    for (int i = 0; i < n; i++) begin
      k = n - 1 - i;
      // command goes last, earlier bits are filler
      sdi_o = (k < 22) ? cmd[k] : k[0];
      #HALF_NS sclk_o = 1'b1;
      if (i < 22) begin
        rd[21 - i] = sdo_i;
      end
      #HALF_NS sclk_o = 1'b0;
    end
    #HALF_NS cs_n_o = 1'b1;
    // released line must not keep looking valid
    sdi_o = ~sdi_o;
    for (int j = 0; j < 60 && !ok; j++) begin
      @(negedge clk_i);
      ok = ready_strobe_i;
    end
  endtask
endmodule
`default_nettype wire
